// >>> logic/spm_entry.sv
`timescale 1ns/1ps
// Purpose: decides serial program mode at reset, remaps vectors, guards flash regions
// Assumes: sync clock level input and link clock port come from the same pin
// Notes: a byte must last at least four system cycles on the link for the crossing
module spm_entry
  import spm_pkg::*;
#(
  parameter int FIRST_CYC = FIRST_CHECK_CYC,
  parameter int WIN_CYC = RELEASE_WINDOW_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic ext_reset_pin_n_i,
  input wire logic sync_serial_clock_pin_i,
  input wire logic sync_serial_data_pin_i,
  input wire logic async_serial_data_pin_i,
  input wire logic flash_busy_i,
  input wire logic fl_req_i,
  input wire logic [19:0] fl_addr_i,
  input wire logic fl_src_parallel_i,
  input wire logic vec_req_i,
  input wire logic [19:0] vec_addr_i,
  output logic prog_mode_o,
  output logic user_mode_o,
  output logic connect_seen_o,
  output logic writer_busy_o,
  output logic writer_busy_oe_o,
  output logic fl_grant_o,
  output logic fl_deny_o,
  output logic vec_valid_o,
  output logic [19:0] vec_addr_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  spm_link_if lnk ();

  spm_link_rx u_rx (
    .link_clk_i(link_clk_i),
    .rst_i(rst_i),
    .sync_serial_data_pin_i(sync_serial_data_pin_i),
    .lnk(lnk)
  );

  // pin synchronisers; first stages feed only the second stages
  logic [4:0] sync_m, sync_s;
  logic rst_n_s, clk_s, dat_s, adat_s, tog_s, tog_d;
  assign rst_n_s = sync_s[0];
  assign clk_s = sync_s[1];
  assign dat_s = sync_s[2];
  assign adat_s = sync_s[3];
  assign tog_s = sync_s[4];

  spm_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_connect;
  logic lines_armed, lines_released;
  assign lines_armed = ~dat_s & clk_s;
  assign lines_released = dat_s & clk_s;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_connect = connect_seen_o;
    if (!rst_n_s) begin
      next_state = ST_IDLE;
      next_cnt = '0;
      next_connect = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // announce seen around release; the programmer holds it long enough
          next_connect = ~adat_s;
          next_state = ST_CHK1;
        end
        ST_CHK1: begin
          next_cnt = '0;
          next_state = lines_armed ? ST_WAIT1 : ST_USER;
        end
        ST_WAIT1: begin
          next_cnt = cnt + 1'b1;
          if (cnt == CNT_W'(FIRST_CYC - 1)) begin
            next_state = ST_CHK2;
          end
        end
        ST_CHK2: begin
          next_cnt = '0;
          next_state = lines_armed ? ST_WIN : ST_USER;
        end
        ST_WIN: begin
          next_cnt = cnt + 1'b1;
          if (lines_released) begin
            next_state = ST_PROG;
          end else if (cnt == CNT_W'(WIN_CYC - 1)) begin
            next_state = ST_USER;
          end
        end
        ST_PROG: next_state = ST_PROG;
        ST_USER: next_state = ST_USER;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // flash region decode
  logic in_loader, in_subvec, in_fixed, next_grant, next_deny;
  assign in_loader = fl_addr_i >= LOADER_FIRST && fl_addr_i < LOADER_FIRST + LOADER_SIZE;
  assign in_subvec = fl_addr_i >= SUBVEC_FIRST && fl_addr_i <= SUBVEC_LAST;
  assign in_fixed = fl_addr_i >= LOADER_FIRST + LOADER_SIZE && fl_addr_i <= FIXED_LAST;

  always_comb begin
    next_grant = 1'b0;
    next_deny = 1'b0;
    if (fl_req_i) begin
      if (in_loader) begin
        next_deny = 1'b1;
      end else if ((in_subvec || in_fixed) && !fl_src_parallel_i) begin
        next_deny = 1'b1;
      end else begin
        next_grant = 1'b1;
      end
    end
  end

  // vector redirection; the loader itself runs from native vectors in program mode
  logic [19:0] next_vec;
  always_comb begin
    next_vec = vec_addr_i;
    if (user_mode_o) begin
      if (vec_addr_i == RESET_VEC) begin
        next_vec = RESET_BRANCH;
      end else if (vec_addr_i >= IRQ_VEC_FIRST && vec_addr_i <= IRQ_VEC_LAST) begin
        next_vec = IRQ_BRANCH_FIRST + (vec_addr_i - IRQ_VEC_FIRST);
      end
    end
  end

  logic next_rx_valid;
  assign lnk.enable = prog_mode_o;
  assign next_rx_valid = prog_mode_o && (tog_s != tog_d);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_m <= 5'h00;
      sync_s <= 5'h00;
      tog_d <= 1'b0;
      state <= ST_IDLE;
      cnt <= '0;
      prog_mode_o <= 1'b0;
      user_mode_o <= 1'b0;
      connect_seen_o <= 1'b0;
      writer_busy_o <= 1'b0;
      writer_busy_oe_o <= 1'b0;
      fl_grant_o <= 1'b0;
      fl_deny_o <= 1'b0;
      vec_valid_o <= 1'b0;
      vec_addr_o <= 20'h00000;
      rx_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end else begin
      sync_m <= {lnk.rx_toggle, async_serial_data_pin_i, sync_serial_data_pin_i,
                 sync_serial_clock_pin_i, ext_reset_pin_n_i};
      sync_s <= sync_m;
      tog_d <= tog_s;
      state <= next_state;
      cnt <= next_cnt;
      prog_mode_o <= next_state == ST_PROG;
      user_mode_o <= next_state == ST_USER;
      connect_seen_o <= next_connect;
      writer_busy_o <= flash_busy_i;
      writer_busy_oe_o <= next_state == ST_PROG;
      fl_grant_o <= next_grant;
      fl_deny_o <= next_deny;
      vec_valid_o <= vec_req_i;
      vec_addr_o <= next_vec;
      rx_valid_o <= next_rx_valid;
      // byte is stable: it changed together with the toggle that was just seen
      if (next_rx_valid) begin
        rx_byte_o <= lnk.rx_byte;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_chk1_fail_user: assert property (
    state == ST_CHK1 && rst_n_s && !lines_armed |=> state == ST_USER && user_mode_o)
    else $error("first check failure did not select user program");

  a_chk2_after_wait: assert property (
    state == ST_CHK2 |-> $past(state) == ST_WAIT1 && $past(cnt) == CNT_W'(FIRST_CYC - 1))
    else $error("second check reached without the full first delay");

  a_chk2_pass_win: assert property (
    state == ST_CHK2 && rst_n_s && lines_armed |=> state == ST_WIN && cnt == '0)
    else $error("second check pass did not open release window");

  a_win_enter_prog: assert property (
    state == ST_WIN && rst_n_s && lines_released
    |=> state == ST_PROG && prog_mode_o && writer_busy_oe_o)
    else $error("released lines did not enter program mode");

  a_win_timeout: assert property (
    state == ST_WIN && rst_n_s && !lines_released && cnt == CNT_W'(WIN_CYC - 1)
    |=> state == ST_USER && user_mode_o && !prog_mode_o)
    else $error("window expiry did not select user program");

  // one edge only: a pin reset seen now may clear the mode on the next edge
  a_decide_once: assert property (
    (prog_mode_o || user_mode_o) && rst_n_s
    |=> $stable(prog_mode_o) && $stable(user_mode_o))
    else $error("mode decision changed without a reset");

  a_loader_deny: assert property (
    fl_req_i && in_loader |=> fl_deny_o && !fl_grant_o)
    else $error("loader region access not refused");

  a_protect_serial: assert property (
    fl_req_i && (in_subvec || in_fixed) && !fl_src_parallel_i |=> fl_deny_o)
    else $error("serial access to protected area not refused");

  a_parallel_grant: assert property (
    fl_req_i && !in_loader && (fl_src_parallel_i || !(in_subvec || in_fixed))
    |=> fl_grant_o && !fl_deny_o)
    else $error("permitted flash access refused");

  a_reset_vector: assert property (
    vec_req_i && user_mode_o && vec_addr_i == RESET_VEC |=> vec_addr_o == RESET_BRANCH)
    else $error("reset vector not redirected");

  a_irq_vector: assert property (
    vec_req_i && user_mode_o && vec_addr_i == 20'h04078 |=> vec_addr_o == 20'h05880)
    else $error("last interrupt vector not redirected to last slot");

  a_busy_follow: assert property (
    prog_mode_o |-> writer_busy_oe_o ##1 writer_busy_o == $past(flash_busy_i))
    else $error("busy pin does not follow flash busy");

  a_busy_oe_user: assert property (
    user_mode_o
    |-> !writer_busy_oe_o)
    else $error("busy pin driven while in user program");

  a_chk1_pass_wait: assert property (
    state == ST_CHK1 && rst_n_s && lines_armed
    |=> state == ST_WAIT1 && cnt == '0)
    else $error("first check pass did not start the delay");

  a_wait_full_count: assert property (
    state == ST_WAIT1 && rst_n_s && cnt != CNT_W'(FIRST_CYC - 1)
    |=> state == ST_WAIT1)
    else $error("first check delay cut short");

  a_chk2_fail_user: assert property (
    state == ST_CHK2 && rst_n_s && !lines_armed
    |=> state == ST_USER && user_mode_o)
    else $error("second check failure did not select user program");

  a_win_wait_stay: assert property (
    state == ST_WIN && rst_n_s && !lines_released && cnt != CNT_W'(WIN_CYC - 1)
    |=> state == ST_WIN)
    else $error("release window closed early");

  // a low reset pin restarts the whole decision, connect flag included
  a_pin_reset_idle: assert property (
    !rst_n_s
    |=> state == ST_IDLE && !prog_mode_o && !user_mode_o && !connect_seen_o)
    else $error("reset pin did not restart entry");

  a_connect_sample: assert property (
    state == ST_IDLE && rst_n_s
    |=> connect_seen_o == !$past(adat_s))
    else $error("connect signal not sampled after reset release");

  a_no_req_idle: assert property (
    !fl_req_i
    |=> !fl_grant_o && !fl_deny_o)
    else $error("flash answer without a request");

  a_vec_valid_follow: assert property (
    vec_req_i
    |=> vec_valid_o)
    else $error("vector request not answered");

  // the loader itself must see native vectors, so no remap before a decision
  a_vec_native_prog: assert property (
    vec_req_i && !user_mode_o
    |=> vec_addr_o == $past(vec_addr_i))
    else $error("vector remapped while the loader runs");

  a_irq_first_slot: assert property (
    vec_req_i && user_mode_o && vec_addr_i == IRQ_VEC_FIRST
    |=> vec_addr_o == IRQ_BRANCH_FIRST)
    else $error("first interrupt vector not redirected to first slot");

  c_prog_entry: cover property (state == ST_WIN ##1 state == ST_PROG);
  c_win_timeout: cover property (state == ST_WIN && !lines_released ##1 state == ST_USER);
  c_rx_byte: cover property (rx_valid_o);
  c_chk2_fail: cover property (state == ST_CHK2 && !lines_armed ##1 state == ST_USER);
  c_loader_deny: cover property (fl_deny_o && $past(in_loader));
endmodule

// >>> logic/spm_pkg.sv
// Purpose: constants, states and address map of the serial program mode entry block
// Assumes: system clock at 20 MHz, 20-bit flash byte addresses
// Notes: times are kept in microseconds and turned into cycle counts here
// Summary of operation
// - loader region refuses every erase and write
// - data low, clock high, wait, check again
// - both lines high within release window
// - any failed check selects user program
// - reset vector redirected to branch slot
// - interrupt vectors redirected to matching slots
// - subroutine vector area: parallel writer only
// - fixed user area: parallel writer only
// - general user area open to both writers
// - busy shown on sync input pin
package spm_pkg;
  localparam int SYS_CLK_MHZ = 20;
  localparam int FIRST_CHECK_DELAY_US = 100;
  localparam int RELEASE_WINDOW_US = 1000;
  // least wait rounds up, longest window rounds down; both are exact at 20 MHz
  localparam int FIRST_CHECK_CYC = FIRST_CHECK_DELAY_US * SYS_CLK_MHZ;
  localparam int RELEASE_WINDOW_CYC = RELEASE_WINDOW_US * SYS_CLK_MHZ;
  localparam int CNT_W = 16;

  localparam int ADDR_W = 20;
  localparam logic [19:0] RESET_VEC = 20'h04000;
  localparam logic [19:0] RESET_BRANCH = 20'h05808;
  localparam logic [19:0] IRQ_VEC_FIRST = 20'h04004;
  localparam logic [19:0] IRQ_VEC_LAST = 20'h04078;
  localparam logic [19:0] IRQ_BRANCH_FIRST = 20'h0580C;
  localparam logic [19:0] SUBVEC_FIRST = 20'h04080;
  localparam logic [19:0] SUBVEC_LAST = 20'h040BF;
  localparam logic [19:0] LOADER_FIRST = 20'h040C0;
  localparam logic [19:0] LOADER_SIZE = 20'h00400;
  localparam logic [19:0] FIXED_LAST = 20'h057FF;

  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CHK1 = 7'h02,
    ST_WAIT1 = 7'h04,
    ST_CHK2 = 7'h08,
    ST_WIN = 7'h10,
    ST_PROG = 7'h20,
    ST_USER = 7'h40
  } spm_state_t;
endpackage

// >>> logic/spm_link_if.sv
`timescale 1ns/1ps
// Purpose: carries received bytes from the link domain to the core domain
// Assumes: byte changes only together with a toggle of rx_toggle
// Notes: enable is a level and is re-synchronised by the link side
interface spm_link_if;
  logic [7:0] rx_byte;
  logic rx_toggle;
  logic enable;
  modport link (output rx_byte, output rx_toggle, input enable);
  modport core (input rx_byte, input rx_toggle, output enable);
endinterface

// >>> logic/spm_link_rx.sv
`timescale 1ns/1ps
// Purpose: shifts programmer data in on the programmer's own serial clock
// Assumes: the link clock only runs during frames
// Notes: a byte in progress when enable drops is held, not flushed
module spm_link_rx
  import spm_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic sync_serial_data_pin_i,
  spm_link_if.link lnk
);
  logic en_m, en_s;
  logic [7:0] shift, next_shift, byte_q, next_byte_q;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic tog, next_tog;

  always_comb begin
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_byte_q = byte_q;
    next_tog = tog;
    if (en_s) begin
      next_shift = {shift[6:0], sync_serial_data_pin_i};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == BIT_LAST) begin
        next_byte_q = {shift[6:0], sync_serial_data_pin_i};
        next_tog = ~tog;
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_m <= 1'b0;
      en_s <= 1'b0;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      byte_q <= 8'h00;
      tog <= 1'b0;
    end else begin
      en_m <= lnk.enable;
      en_s <= en_m;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      byte_q <= next_byte_q;
      tog <= next_tog;
    end
  end

  assign lnk.rx_byte = byte_q;
  assign lnk.rx_toggle = tog;
endmodule

// >>> test/spm_prog_model.sv
`timescale 1ns/1ps
// Purpose: serial programmer model driving the entry pins and the link clock
// Assumes: pull-ups on every line, so released lines and an idle clock sit high
// Notes: fault 1 spoils the first check, fault 2 never raises data in the window,
// fault 3 raises data during the first delay so the second check fails
module spm_prog_model #(
  parameter int HOLD_CYC = 4
)
(
  input wire logic sys_clk_i,
  output logic rst_n_o,
  output logic clk_o,
  output logic data_o,
  output logic async_o
);
  initial begin
    rst_n_o = 1'b0;
    clk_o = 1'b0;
    data_o = 1'b1;
    async_o = 1'b1;
    #60 clk_o = 1'b1;
  end
  task automatic entry(input int fault);
    @(posedge sys_clk_i);
    #1;
    rst_n_o = 1'b0;
    clk_o = 1'b0;
    data_o = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    clk_o = 1'b1;
    async_o = 1'b0;
    repeat (HOLD_CYC) @(posedge sys_clk_i);
    #1;
    rst_n_o = 1'b1;
    data_o = (fault == 1);
    repeat (3) @(posedge sys_clk_i);
    #1;
    data_o = (fault == 1 || fault == 3);
    repeat (6) @(posedge sys_clk_i);
    #1;
    async_o = 1'b1;
    data_o = (fault != 2);
  endtask
  // the link side only sees its enable after two of its own clock edges
  task automatic wake();
    repeat (2) begin
      clk_o = 1'b0;
      #3 clk_o = 1'b1;
      #3;
    end
    @(posedge sys_clk_i);
    #1;
  endtask
  // gap after each byte keeps the crossing from dropping it
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      clk_o = 1'b0;
      data_o = b[i];
      #3 clk_o = 1'b1;
      #3;
    end
    data_o = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
  endtask
endmodule

// >>> test/spm_entry_tb.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the serial program mode entry block
// Assumes: short check delay and window, programmer model on the pins
// Notes: flash and vector expectations come from the functions below
module spm_entry_tb;
  import spm_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rst_n, pclk, pdata, pasync, prog, user, conn, wbusy, wbusy_oe, grant, deny, vvalid, rxv;
  logic fl_busy = 1'b0, fl_req = 1'b0, fl_par = 1'b0, vec_req = 1'b0, um = 1'b0;
  logic [19:0] fl_addr = 20'h00000, vec_addr = 20'h00000, vout;
  logic [7:0] rxb;
  logic [7:0] rxq[$];
  logic [31:0] seed = 32'h00009476;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  spm_prog_model i_spm_prog_model (.sys_clk_i(sys_clk_i), .rst_n_o(rst_n), .clk_o(pclk),
    .data_o(pdata), .async_o(pasync));
  spm_entry #(.FIRST_CYC(4), .WIN_CYC(8)) i_spm_entry (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link_clk_i(pclk), .ext_reset_pin_n_i(rst_n), .sync_serial_clock_pin_i(pclk),
    .sync_serial_data_pin_i(pdata), .async_serial_data_pin_i(pasync), .flash_busy_i(fl_busy),
    .fl_req_i(fl_req), .fl_addr_i(fl_addr), .fl_src_parallel_i(fl_par), .vec_req_i(vec_req),
    .vec_addr_i(vec_addr), .prog_mode_o(prog), .user_mode_o(user), .connect_seen_o(conn),
    .writer_busy_o(wbusy), .writer_busy_oe_o(wbusy_oe), .fl_grant_o(grant), .fl_deny_o(deny),
    .vec_valid_o(vvalid), .vec_addr_o(vout), .rx_valid_o(rxv), .rx_byte_o(rxb));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic fl_ok(input logic [19:0] a, input logic p);
    if (a >= LOADER_FIRST && a < LOADER_FIRST + LOADER_SIZE)
      return 1'b0;
    if (!p && ((a >= SUBVEC_FIRST && a <= SUBVEC_LAST) ||
        (a >= LOADER_FIRST + LOADER_SIZE && a <= FIXED_LAST)))
      return 1'b0;
    return 1'b1;
  endfunction
  function automatic logic [19:0] vexp(input logic [19:0] a);
    if (um && a == RESET_VEC)
      return RESET_BRANCH;
    if (um && a >= IRQ_VEC_FIRST && a <= IRQ_VEC_LAST)
      return a - IRQ_VEC_FIRST + IRQ_BRANCH_FIRST;
    return a;
  endfunction
  // pulses are looked at mid-cycle, away from the edge that sets them
  always @(negedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
    if (rxv === 1'b1)
      chk("rx_byte", 20'(rxq.pop_front()), 20'(rxb));
  end
  task automatic op(input logic [19:0] fa, input logic p, input logic [19:0] va);
    fl_req = 1'b1;
    fl_addr = fa;
    fl_par = p;
    vec_req = 1'b1;
    vec_addr = va;
    fl_busy = seed[5];
    @(posedge sys_clk_i);
    #1;
    chk("grant", 20'(fl_ok(fa, p)), 20'(grant));
    chk("deny", 20'(!fl_ok(fa, p)), 20'(deny));
    chk("vec_addr", vexp(va), vout);
    chk("vec_valid", 20'h00001, 20'(vvalid));
    chk("busy", 20'(seed[5]), 20'(wbusy));
    chk("busy_oe", 20'(!um), 20'(wbusy_oe));
  endtask
  task automatic sweep();
    op(20'h040C0, 1'b1, RESET_VEC);
    op(20'h044BF, 1'b0, IRQ_VEC_FIRST);
    op(20'h04080, 1'b0, IRQ_VEC_LAST);
    op(20'h040BF, 1'b1, 20'h0407C);
    op(20'h044C0, 1'b0, 20'h04002);
    op(20'h057FF, 1'b1, 20'h03FFC);
    op(20'h05800, 1'b0, 20'h04040);
    op(20'h0407F, 1'b0, 20'h04000);
    for (int i = 0; i < 24; i++) begin
      void'(rnd());
      op(20'h04000 + 20'(seed[15:0] % 16'h1C00), seed[16], 20'h04000 + 20'({seed[23:19], 2'b00}));
    end
    fl_req = 1'b0;
    vec_req = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic enter(input int f, input logic p);
    i_spm_prog_model.entry(f);
    repeat (40) if ((prog | user) !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
    end
    um = ~p;
    chk("prog_mode", 20'(p), 20'(prog));
    chk("user_mode", 20'(!p), 20'(user));
    chk("connect", 20'h00001, 20'(conn));
    $display("test entry %0d done", f);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("reset_outputs", 20'h00000, 20'({prog, user, conn, wbusy_oe, rxv}));
    enter(0, 1'b1);
    sweep();
    i_spm_prog_model.wake();
    for (int i = 0; i < 4; i++) begin
      void'(rnd());
      rxq.push_back(seed[7:0]);
      i_spm_prog_model.send(seed[7:0]);
    end
    chk("rx_left", 20'h00000, 20'(rxq.size()));
    $display("test link bytes done");
    enter(1, 1'b0);
    sweep();
    enter(3, 1'b0);
    enter(2, 1'b0);
    repeat (30) @(posedge sys_clk_i);
    #1;
    chk("user_hold", 20'h00001, 20'(user));
    finish_test();
  end
endmodule
